//--- rtl/pulse_link_defines.svh
`ifndef PULSE_LINK_DEFINES_SVH
`define PULSE_LINK_DEFINES_SVH
`define CLK_HZ         40000000
`define FAST_HZ        10000
`define SLOW_HZ        10
`define BLINK_HZ       1
`define FAST_HALF      (`CLK_HZ / (2 * `FAST_HZ))
`define SLOW_HALF      (`CLK_HZ / (2 * `SLOW_HZ))
`define BLINK_HALF     (`CLK_HZ / (2 * `BLINK_HZ))
`define CNT_W          30
`define CODE_MIN       3'h0
`define LINK_TIMEOUT   (`CLK_HZ / 2)
`endif

//--- rtl/pulse_link_pkg.sv
package pulse_link_pkg;
	typedef logic [29:0] count_t;
	typedef logic [2:0]  code_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HIGH = 3'b010,
		ST_LOW  = 3'b100
	} gen_state_e;
endpackage : pulse_link_pkg

//--- rtl/pulse_chan_if.sv
`timescale 1ns/1ps
interface pulse_chan_if;
	logic        freq_mode;
	logic        slow;
	logic        load;
	logic [29:0] count;
	logic [31:0] half_period;
	logic        pulse;
	logic        busy;
	modport ctrl (output freq_mode, slow, load, count, half_period, input pulse, busy);
	modport gen  (input freq_mode, slow, load, count, half_period, output pulse, busy);
endinterface : pulse_chan_if

//--- rtl/pulse_gen.sv
`timescale 1ns/1ps
`include "pulse_link_defines.svh"
module pulse_gen
	import pulse_link_pkg::*;
#(
	parameter int FAST_HALF = `FAST_HALF,
	parameter int SLOW_HALF = `SLOW_HALF
) (
	// Clock and reset
	input  wire logic   ref_clk,
	input  wire logic   rst_b,
	// Channel
	pulse_chan_if.gen   ch
);
	gen_state_e  state_q;
	logic [31:0] tick_q;
	count_t      pend_q;
	logic [31:0] half;
	count_t      pend_left;

	// Pending count once the current period ends, with any new delta folded in
	always_comb begin
		pend_left = pend_q - 30'h1;
		if (ch.load) begin
			pend_left = pend_q - 30'h1 + ch.count;
		end
	end

	always_comb begin
		if (ch.freq_mode) begin
			half = ch.half_period;
		end else if (ch.slow) begin
			half = 32'(SLOW_HALF);
		end else begin
			half = 32'(FAST_HALF);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			tick_q  <= 32'h0;
			pend_q  <= 30'h0;
		end else begin
			if (ch.load && !ch.freq_mode) begin
				pend_q <= pend_q + ch.count;
			end
			case (state_q)
				ST_IDLE: begin
					tick_q <= 32'h0;
					if (ch.freq_mode ? (ch.half_period != 32'h0) : (pend_q != 30'h0)) begin
						state_q <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (tick_q + 32'h1 >= half) begin
						tick_q  <= 32'h0;
						state_q <= ST_LOW;
					end else begin
						tick_q <= tick_q + 32'h1;
					end
				end
				ST_LOW: begin
					if (tick_q + 32'h1 >= half) begin
						tick_q <= 32'h0;
						if (!ch.freq_mode) begin
							pend_q <= pend_left;
						end
						// Next period starts at once so the low phase stays one half
						if (ch.freq_mode ? (ch.half_period != 32'h0) : (pend_left != 30'h0)) begin
							state_q <= ST_HIGH;
						end else begin
							state_q <= ST_IDLE;
						end
					end else begin
						tick_q <= tick_q + 32'h1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign ch.pulse = (state_q == ST_HIGH);
	assign ch.busy  = (state_q != ST_IDLE);
endmodule : pulse_gen

//--- rtl/pulse_link_out.sv
`timescale 1ns/1ps
`include "pulse_link_defines.svh"
// Contract
// - The pairing code from the rotary selector is the address tying an input to an output module.
// - Data is accepted only from a partner carrying the identical pairing code.
// - The status indicator is steady on while the link is up and signals can pass.
// - The status indicator blinks when no matching partner exists or functions differ.
// - Both paired modules must be set to the same function for normal operation.
// - An input activity indicator is lit while a pulse is present on that input.
// - An output activity indicator is lit while that output drives a pulse.
// - Pairing code and configuration are sampled only once after power-up reset.
// - Counting mode emits the pulses as 50% square waves at 10 kHz or 10 Hz.
// - Frequency mode reproduces the measured frequency at 50% duty.
// - Counting mode outputs the new accumulated count minus the previous one.
// - The input side keeps a 30-bit accumulating counter across link loss.
// - Speed off selects 10 kHz and on selects 10 Hz, in counting mode only.
module pulse_link_out
	import pulse_link_pkg::*;
#(
	parameter int CH           = 2,
	parameter int FAST_HALF    = `FAST_HALF,
	parameter int SLOW_HALF    = `SLOW_HALF,
	parameter int BLINK_HALF   = `BLINK_HALF,
	parameter int LINK_TIMEOUT = `LINK_TIMEOUT
) (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst_b,
	// Strap inputs
	input  wire pulse_link_pkg::code_t  pair_code,
	input  wire logic [CH-1:0]          freq_mode_sw,
	input  wire logic [CH-1:0]          slow_sw,
	// Link receive
	input  wire logic                   rx_valid,
	input  wire pulse_link_pkg::code_t  rx_code,
	input  wire logic                   rx_chan,
	input  wire logic                   rx_freq_mode,
	input  wire logic [29:0]            rx_value,
	input  wire logic                   rx_resync,
	// Pin outputs and indicators
	output logic [CH-1:0]               pulse_out,
	output logic [CH-1:0]               act_led,
	output logic                        status_led,
	output logic                        mismatch
);
	code_t          code_q;
	logic [CH-1:0]  fmode_q;
	logic [CH-1:0]  slow_q;
	logic           strap_q;
	logic [31:0]    blink_cnt_q;
	logic           blink_q;
	logic [31:0]    alive_q;
	logic           link_up_q;
	logic           func_bad_q;
	logic [CH-1:0]  have_last_q;
	count_t         last_q [CH];

	// Straps caught once after reset release
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_q <= 1'b0;
			code_q  <= `CODE_MIN;
			fmode_q <= '0;
			slow_q  <= '0;
		end else if (!strap_q) begin
			strap_q <= 1'b1;
			code_q  <= pair_code;
			fmode_q <= freq_mode_sw;
			slow_q  <= slow_sw;
		end
	end

	wire frame_ok = strap_q && rx_valid && (rx_code == code_q);
	wire fmatch   = (rx_freq_mode == fmode_q[rx_chan]);

	// Link supervision
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			alive_q    <= 32'h0;
			link_up_q  <= 1'b0;
			func_bad_q <= 1'b0;
		end else if (frame_ok) begin
			alive_q    <= 32'(LINK_TIMEOUT);
			link_up_q  <= 1'b1;
			func_bad_q <= !fmatch;
		end else if (alive_q != 32'h0) begin
			alive_q <= alive_q - 32'h1;
		end else begin
			link_up_q <= 1'b0;
		end
	end

	// Blink divider
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			blink_cnt_q <= 32'h0;
			blink_q     <= 1'b0;
		end else if (blink_cnt_q + 32'h1 >= 32'(BLINK_HALF)) begin
			blink_cnt_q <= 32'h0;
			blink_q     <= !blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h1;
		end
	end

	wire good = link_up_q && !func_bad_q;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			status_led <= 1'b0;
			mismatch   <= 1'b0;
		end else begin
			status_led <= good ? 1'b1 : blink_q;
			mismatch   <= !good;
		end
	end

	genvar i;
	generate
		for (i = 0; i < CH; i++) begin : g_ch
			pulse_chan_if ch_if ();
			wire hit = frame_ok && fmatch && (rx_chan == 1'(i));

			// Delta of accumulated counts; first or resync frame only seeds the base
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					last_q[i]      <= 30'h0;
					have_last_q[i] <= 1'b0;
				end else if (hit && !fmode_q[i]) begin
					last_q[i]      <= rx_value;
					have_last_q[i] <= 1'b1;
				end else if (hit) begin
					// Frequency frames carry a half period in clocks
					last_q[i] <= rx_value;
				end
			end

			assign ch_if.freq_mode   = fmode_q[i];
			assign ch_if.slow        = slow_q[i] && !fmode_q[i];
			assign ch_if.load        = hit && !fmode_q[i] && have_last_q[i] && !rx_resync;
			assign ch_if.count       = rx_value - last_q[i];
			assign ch_if.half_period = (fmode_q[i] && link_up_q && !func_bad_q)
				? {2'h0, last_q[i]} : 32'h0;

			pulse_gen #(
				.FAST_HALF (FAST_HALF),
				.SLOW_HALF (SLOW_HALF)
			) u_gen (
				.ref_clk (ref_clk),
				.rst_b   (rst_b),
				.ch      (ch_if.gen)
			);

			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					pulse_out[i] <= 1'b0;
					act_led[i]   <= 1'b0;
				end else begin
					pulse_out[i] <= ch_if.pulse;
					act_led[i]   <= ch_if.pulse;
				end
			end
		end
	endgenerate
endmodule : pulse_link_out

//--- tb/pulse_link_out_sva.sv
`timescale 1ns/1ps
module pulse_link_out_sva
	import pulse_link_pkg::*;
#(
	parameter int FAST_HALF = 4,
	parameter int SLOW_HALF = 8
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	input  wire pulse_link_pkg::code_t pair_code,
	input  wire pulse_link_pkg::code_t rx_code,
	input  wire logic [1:0]            freq_mode_sw,
	input  wire logic [1:0]            pulse_out,
	input  wire logic [1:0]            act_led,
	input  wire logic                  rx_valid,
	input  wire logic                  rx_chan,
	input  wire logic                  rx_freq_mode,
	input  wire logic                  status_led,
	input  wire logic                  mismatch
);
	logic [31:0] hi_q;
	logic        cap_q;
	code_t       code_cap_q;
	logic [1:0]  mode_cap_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Length of the current high run on channel 0
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) hi_q <= 32'h0;
		else hi_q <= pulse_out[0] ? hi_q + 32'h1 : 32'h0;
	end
	// Straps as caught once after reset release
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cap_q      <= 1'b0;
			code_cap_q <= 3'h0;
			mode_cap_q <= 2'h0;
		end else if (!cap_q) begin
			cap_q      <= 1'b1;
			code_cap_q <= pair_code;
			mode_cap_q <= freq_mode_sw;
		end
	end
	led_follow_a: assert property (act_led == pulse_out) else $error("led differs");
	high_width_a: assert property ($fell(pulse_out[0]) && !freq_mode_sw[0] |->
		hi_q == FAST_HALF || hi_q == SLOW_HALF) else $error("bad high width");
	low_width_a: assert property ($fell(pulse_out[0]) && !freq_mode_sw[0] |->
		!pulse_out[0] [*4]) else $error("low phase too short");
	link_on_a: assert property (cap_q && rx_valid && rx_code == code_cap_q &&
		rx_freq_mode == mode_cap_q[rx_chan] |-> ##[1:3] (status_led && !mismatch))
		else $error("status not on");
	mismatch_flag_a: assert property (cap_q && rx_valid && rx_code == code_cap_q &&
		rx_freq_mode != mode_cap_q[rx_chan] |-> ##[1:3] mismatch) else $error("no flag");
	blink_start_a: assert property (mismatch |->
		##[1:40] ($changed(status_led) || !mismatch)) else $error("status not blinking");
	blink_hold_a: assert property ($changed(status_led) && mismatch && $past(mismatch)
		|=> ($stable(status_led) || $changed(mismatch)) [*8]) else $error("blink too fast");
	reset_quiet_a: assert property ($rose(rst_b) |-> (pulse_out == 2'h0) [*3])
		else $error("output not quiet");
endmodule : pulse_link_out_sva
bind pulse_link_out pulse_link_out_sva #(.FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF))
	pulse_link_out_sva_inst (.ref_clk(ref_clk), .rst_b(rst_b), .pair_code(pair_code),
	.rx_code(rx_code), .freq_mode_sw(freq_mode_sw), .pulse_out(pulse_out),
	.act_led(act_led), .rx_valid(rx_valid), .rx_chan(rx_chan),
	.rx_freq_mode(rx_freq_mode), .status_led(status_led), .mismatch(mismatch));

//--- tb/frame_src.sv
`timescale 1ns/1ps
module frame_src (
	input  wire logic  ref_clk,
	output logic       rx_valid,
	output logic [2:0] rx_code,
	output logic       rx_chan,
	output logic       rx_freq_mode,
	output logic [29:0] rx_value
);
	initial {rx_valid, rx_code, rx_chan, rx_freq_mode, rx_value} = '0;
	// One frame; value goes stale (inverted) once valid drops
	task send(input logic [2:0] c, input logic ch, input logic fm, input logic [29:0] v);
		@(posedge ref_clk);
		#1 {rx_valid, rx_code, rx_chan, rx_freq_mode, rx_value} = {1'b1, c, ch, fm, v};
		@(posedge ref_clk);
		#1 rx_valid = 1'b0;
		rx_value = ~v;
	endtask : send
endmodule : frame_src

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import pulse_link_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [1:0]  slow_sw = 2'h0;
	logic [1:0]  freq_mode_sw = 2'h2;
	code_t       pair_code = 3'h5;
	logic        rx_resync = 1'b0;
	logic        rx_valid, rx_chan, rx_freq_mode, status_led, mismatch;
	code_t       rx_code;
	logic [29:0] rx_value;
	logic [1:0]  pulse_out, act_led;
	int          bad_count = 0;
	int          checks_done = 0;
	int          n, w;
	always #12.5 ref_clk = ~ref_clk;
	frame_src frame_src_inst (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_code(rx_code),
		.rx_chan(rx_chan), .rx_freq_mode(rx_freq_mode), .rx_value(rx_value));
	pulse_link_out #(.FAST_HALF(4), .SLOW_HALF(8), .BLINK_HALF(16), .LINK_TIMEOUT(50))
		pulse_link_out_inst (.ref_clk(ref_clk), .rst_b(rst_b), .pair_code(pair_code),
		.freq_mode_sw(freq_mode_sw), .slow_sw(slow_sw), .rx_valid(rx_valid), .rx_code(rx_code),
		.rx_chan(rx_chan), .rx_freq_mode(rx_freq_mode), .rx_value(rx_value),
		.rx_resync(rx_resync), .pulse_out(pulse_out), .act_led(act_led),
		.status_led(status_led), .mismatch(mismatch));
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask : chk
	task reset_dut(input logic s);
		#1 rst_b = 1'b0;
		slow_sw = {1'b0, s};
		pair_code = 3'h5;
		freq_mode_sw = 2'h2;
		repeat (8) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask : reset_dut
	// Pulse count and first high width over a fixed window
	task automatic meas(input int ch);
		logic p;
		p = 1'b0;
		n = 0;
		w = 0;
		repeat (300) begin
			@(posedge ref_clk);
			#1 if (pulse_out[ch] === 1'b1 && !p) n++;
			if (pulse_out[ch] === 1'b1 && n == 1) w++;
			p = pulse_out[ch];
		end
	endtask : meas
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		wrap_up();
	end
	initial begin
		reset_dut(1'b0);
		frame_src_inst.send(3'h5, 1'b0, 1'b0, 30'h3FFFFFFE);
		repeat (2) @(posedge ref_clk);
		#1 chk(status_led, 1);
		frame_src_inst.send(3'h5, 1'b0, 1'b0, 30'h1);
		meas(0);
		chk(n, 3);
		chk(w, 4);
		chk(mismatch, 1);
		slow_sw = 2'h1;
		freq_mode_sw = 2'h0;
		frame_src_inst.send(3'h5, 1'b0, 1'b0, 30'h3);
		meas(0);
		chk(n, 2);
		chk(w, 4);
		pair_code = 3'h4;
		frame_src_inst.send(3'h4, 1'b0, 1'b0, 30'h9);
		meas(0);
		chk(n, 0);
		frame_src_inst.send(3'h5, 1'b1, 1'b1, 30'h6);
		meas(1);
		chk(w, 6);
		frame_src_inst.send(3'h5, 1'b1, 1'b1, 30'h6);
		repeat (3) @(posedge ref_clk);
		#1 chk(mismatch, 0);
		frame_src_inst.send(3'h5, 1'b0, 1'b1, 30'h7);
		repeat (3) @(posedge ref_clk);
		#1 chk(mismatch, 1);
		repeat (60) @(posedge ref_clk);
		reset_dut(1'b1);
		frame_src_inst.send(3'h5, 1'b0, 1'b0, 30'h0);
		frame_src_inst.send(3'h5, 1'b0, 1'b0, 30'h2);
		meas(0);
		chk(n, 2);
		chk(w, 8);
		rx_resync = 1'b1;
		frame_src_inst.send(3'h5, 1'b0, 1'b0, 30'h20);
		rx_resync = 1'b0;
		frame_src_inst.send(3'h5, 1'b0, 1'b0, 30'h21);
		meas(0);
		chk(n, 1);
		wrap_up();
	end
endmodule : tb_top
